// *** sim/flash_mode_protect_ctrl_tb.sv ***
// Self-checking bench for the flash mode and protection controller.
`default_nettype none
module flash_mode_protect_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] PROT = 32'h0000_0005;
   localparam logic [21:0] IDA [5] = '{fmpc_pkg::ID_MAKER_A, fmpc_pkg::ID_CONFIG_A, fmpc_pkg::ID_DEVICE_A,
      fmpc_pkg::ID_GROUP_A | 22'h040000, fmpc_pkg::ID_GROUP_A | 22'h020000};
   logic        clk_sys, sys_rst, op_valid, wp_level, hv_clear_req, op_ready, op_done, in_ident, in_bypass;
   logic        ce_n, oe_n, we_n, dq_oe, clear_n, clear_hv, wp_n, wp_boost, a9_hv;
   logic [2:0]  op_code;
   logic [21:0] op_addr, a_out;
   logic [15:0] op_data, op_rdata, dq_out, dq_in;
   logic [3:0]  nprog;
   logic [15:0] em [logic [21:0]];
   int          err_count, n_tests;
   bit          e_ident, e_byp, e_boost;
   fmpc_ctrl dut_u (.*);
   fmpc_flash_model #(.PROT(PROT)) dev_u (.*);
   // Clock generation.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Prints counts and verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compares one value and counts the result.
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      n_tests++;
      if (got !== ex) begin
         $display("BAD %s exp %h got %h", nm, ex, got);
         err_count++;
      end
   endtask
   // Issues one operation and waits for its completion pulse.
   task automatic do_op(input logic [2:0] c, input logic [21:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code <= c;
      op_addr <= a;
      op_data <= d;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (op_ready !== 1'b1 && n < 50);
      op_valid <= 1'b0;
      if (n >= 50) err_count++;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (op_done !== 1'b1 && n < 200);
      chk("op_done", 16'd1, {15'h0, op_done});
   endtask
   // Reference read value from the bench's own view of the device.
   function automatic logic [15:0] exp_rd(input logic [21:0] a);
      if (!e_ident) return em.exists(a) ? em[a] : 16'hffff;
      if (a[1:0] == 2'b01) return dev_u.DEVID;
      if (a[1:0] == 2'b10) return {15'h0, PROT[a[21:17]]};
      return a[8] ? dev_u.MAKER : dev_u.CONFIG;
   endfunction
   task automatic rd_chk(input logic [21:0] a);
      do_op(fmpc_pkg::FMPC_OP_READ, a, 16'h0);
      chk("rdata", exp_rd(a), op_rdata);
   endtask
   // Programs a random word and checks write count and stored result.
   task automatic prog_chk(input logic [21:0] a);
      logic [15:0] d;
      d = 16'($urandom);
      do_op(fmpc_pkg::FMPC_OP_PROG, a, d);
      if (e_boost || !((PROT[a[21:17]] && !hv_clear_req) || (!wp_level && (a[21:15] == 7'h00 || a[21:15] == 7'h7f))))
         em[a] = d;
      chk("prog writes", (e_byp || e_boost) ? 16'd2 : 16'd4, {12'h0, nprog});
      rd_chk(a);
   endtask
   // Levels settle for a few cycles after a pin request changes.
   task automatic pins(input logic wp, input logic hv);
      wp_level <= wp;
      hv_clear_req <= hv;
      e_boost = e_boost && wp;
      repeat (4) @(posedge clk_sys);
   endtask
   // Main sequence.
   initial begin
      sys_rst = 1'b1; op_valid = 1'b0; op_code = 3'h0; op_addr = 22'h0; op_data = 16'h0;
      wp_level = 1'b1; hv_clear_req = 1'b0; err_count = 0; n_tests = 0;
      void'($urandom(10));
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd_chk({5'd1, 17'($urandom)});
      do_op(fmpc_pkg::FMPC_OP_IDENT, 22'h0, 16'h0);
      e_ident = 1;
      chk("in_ident", 16'd1, {15'h0, in_ident});
      for (int i = 0; i < 5; i++) rd_chk(IDA[i]);
      do_op(fmpc_pkg::FMPC_OP_WRITE, 22'h0, 16'h0000);
      rd_chk(fmpc_pkg::ID_DEVICE_A);
      do_op(fmpc_pkg::FMPC_OP_RESET, 22'h0, 16'h0);
      e_ident = 0;
      chk("in_ident", 16'd0, {15'h0, in_ident});
      prog_chk({5'd1, 17'($urandom)});
      prog_chk(22'h040010);
      do_op(fmpc_pkg::FMPC_OP_BYP_ON, 22'h0, 16'h0);
      e_byp = 1;
      e_boost = 1;
      chk("in_bypass", 16'd1, {15'h0, in_bypass});
      chk("wp_boost", 16'd1, {15'h0, wp_boost});
      prog_chk(22'h040010);
      do_op(fmpc_pkg::FMPC_OP_BYP_OFF, 22'h0, 16'h0);
      e_byp = 0;
      chk("in_bypass", 16'd0, {15'h0, in_bypass});
      pins(1'b0, 1'b0);
      prog_chk(22'h3f8004);
      pins(1'b0, 1'b1);
      prog_chk(22'h000200);
      prog_chk(22'h040020);
      pins(1'b0, 1'b0);
      prog_chk(22'h040030);
      pins(1'b1, 1'b0);
      prog_chk(22'h3f8008);
      do_op(fmpc_pkg::FMPC_OP_WRITE, fmpc_pkg::UNLOCK_A1, fmpc_pkg::CMD_RESET);
      do_op(fmpc_pkg::FMPC_OP_IDENT, 22'h0, 16'h0);
      do_op(fmpc_pkg::FMPC_OP_CLEAR, 22'h0, 16'h0);
      chk("in_ident", 16'd0, {15'h0, in_ident});
      rd_chk(22'h040020);
      complete_run();
   end
   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire

// *** sim/fmpc_flash_model.sv ***
// Behavioural flash device driven through its pins.
`default_nettype none
module fmpc_flash_model #(
   // Identification values are arbitrary.
   parameter logic [15:0] MAKER  = 16'h00a5,
   parameter logic [15:0] CONFIG = 16'h005a,
   parameter logic [15:0] DEVID  = 16'h1357,
   parameter logic [31:0] PROT   = 32'h0000_0005
) (
   // Strobes and buses.
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [21:0] a_out,
   input  wire logic [15:0] dq_out,
   input  wire logic        dq_oe,
   output logic      [15:0] dq_in,
   input  wire logic        clear_n,
   input  wire logic        clear_hv,
   input  wire logic        wp_n,
   input  wire logic        wp_boost,
   input  wire logic        a9_hv,
   // Write count of the last program.
   output logic      [3:0]  nprog
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [logic [21:0]];
   logic [15:0] last, ld;
   logic [21:0] la;
   logic [2:0]  step;
   logic [3:0]  nwr;
   logic        ident, byp, wr, rdq;
   time         t0;
   initial begin
      step = 0; ident = 0; byp = 0; nwr = 0; nprog = 0; last = 0; t0 = 0;
   end
   assign wr = !ce_n && !we_n && oe_n;
   assign rdq = !ce_n && !oe_n && we_n && clear_n;
   always @* begin
      if (dq_oe) dq_in = dq_out;
      else if (!rdq) dq_in = ~last;
      else if (!ident) dq_in = mem.exists(a_out) ? mem[a_out] : 16'hffff;
      else if (a_out[1:0] == 2'b01) dq_in = DEVID;
      else if (a_out[1:0] == 2'b10) dq_in = {15'h0, PROT[a_out[21:17]]};
      else dq_in = a_out[8] ? MAKER : CONFIG;
   end
   // Keeps the last driven word so a released bus shows its inverse.
   always @(dq_in) if (rdq && !dq_oe) last = dq_in;
   // Captures address and data while the write strobes are low.
   always @* if (wr) begin la = a_out; ld = dq_out; end
   function automatic logic blocked(input logic [21:0] a);
      return !wp_boost && ((PROT[a[21:17]] && !clear_hv) || (!wp_n && (a[21:15] == 7'h00 || a[21:15] == 7'h7f)));
   endfunction
   // Command decode at end of write.
   always @(negedge wr) begin
      nwr = (step == 0) ? 4'd1 : nwr + 4'd1;
      if (step == 3) begin
         nprog = nwr;
         if (!blocked(la)) mem[la] = ld;
         step = 0;
      end else if (ld == fmpc_pkg::CMD_RESET) begin
         step = 0;
         ident = 0;
      end else if (byp || wp_boost) begin
         if (step == 5 && ld == fmpc_pkg::CMD_BYP_EXIT1) byp = 0;
         step = (ld == fmpc_pkg::CMD_PROG) ? 3'd3 : (ld == fmpc_pkg::CMD_BYP_EXIT0) ? 3'd5 : 3'd0;
      end else if (step == 0) step = (la[10:0] == 11'h555 && ld == fmpc_pkg::UNLOCK_D1) ? 3'd1 : 3'd0;
      else if (step == 1) step = (la[10:0] == 11'h2aa && ld == fmpc_pkg::UNLOCK_D2) ? 3'd2 : 3'd0;
      else begin
         ident = ident | (ld == fmpc_pkg::CMD_IDENT && !a9_hv);
         byp = (ld == fmpc_pkg::CMD_BYPASS);
         step = (ld == fmpc_pkg::CMD_PROG) ? 3'd3 : 3'd0;
      end
   end
   // A long enough clear pulse aborts to array read.
   always @(negedge clear_n) t0 = $time;
   always @(posedge clear_n) if ($time - t0 >= fmpc_pkg::CLEAR_PULSE_MIN_NS) begin
      step = 0; ident = 0; byp = 0;
   end
   always @(negedge wp_boost) byp = 0;
endmodule
`default_nettype wire

// *** verilog/fmpc_ctrl.sv ***
// Host controller that drives a parallel flash through its pins for modes and protection.
`default_nettype none
module fmpc_ctrl (
   // Clock and reset.
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   // User command port.
   input  wire logic                        op_valid,
   input  wire logic [2:0]                  op_code,
   input  wire logic [fmpc_pkg::ADDR_W-1:0] op_addr,
   input  wire logic [fmpc_pkg::DATA_W-1:0] op_data,
   input  wire logic                        wp_level,
   input  wire logic                        hv_clear_req,
   output logic                             op_ready,
   output logic                             op_done,
   output logic [fmpc_pkg::DATA_W-1:0]      op_rdata,
   output logic                             in_ident,
   output logic                             in_bypass,
   // Flash pins.
   output logic                             ce_n,
   output logic                             oe_n,
   output logic                             we_n,
   output logic [fmpc_pkg::ADDR_W-1:0]      a_out,
   output logic [fmpc_pkg::DATA_W-1:0]      dq_out,
   output logic                             dq_oe,
   input  wire logic [fmpc_pkg::DATA_W-1:0] dq_in,
   output logic                             clear_n,
   output logic                             clear_hv,
   output logic                             wp_n,
   output logic                             wp_boost,
   output logic                             a9_hv
);
   timeunit 1ns / 100ps;
   typedef enum logic [2:0] {
      FMPC_IDLE  = 3'b000,
      FMPC_SEQ   = 3'b001,
      FMPC_WAIT  = 3'b010,
      FMPC_CLEAR = 3'b011,
      FMPC_FIN   = 3'b101
   } fmpc_st_e;

   fmpc_st_e                    st_reg;
   logic [2:0]                  op_reg;
   logic [fmpc_pkg::ADDR_W-1:0] addr_reg;
   logic [fmpc_pkg::DATA_W-1:0] data_reg;
   logic [2:0]                  step_reg;
   logic [2:0]                  nsteps_reg;
   logic [fmpc_pkg::CNT_W-1:0]  tmr_reg;
   logic                        boost_next;
   logic                        go;
   logic                        cyc_read;
   logic [fmpc_pkg::ADDR_W-1:0] cyc_addr;
   logic [fmpc_pkg::DATA_W-1:0] cyc_data;
   logic                        cyc_done;
   logic [fmpc_pkg::DATA_W-1:0] cyc_rdata;

   fmpc_cycle u_cycle (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .go      (go),
      .is_read (cyc_read),
      .addr    (cyc_addr),
      .wdata   (cyc_data),
      .done    (cyc_done),
      .rdata   (cyc_rdata),
      .ce_n    (ce_n),
      .oe_n    (oe_n),
      .we_n    (we_n),
      .a_out   (a_out),
      .dq_out  (dq_out),
      .dq_oe   (dq_oe),
      .dq_in   (dq_in)
   );

   // Selects the bus cycle for the current step of the running operation.
   always_comb begin
      cyc_read = 1'b0;
      cyc_addr = addr_reg;
      cyc_data = data_reg;
      unique case (op_reg)
         fmpc_pkg::FMPC_OP_READ: begin
            // Plain array read; address passes unchanged.
            cyc_read = 1'b1;
         end
         fmpc_pkg::FMPC_OP_PROG: begin
            // Four writes normally, two in bypass.
            if (in_bypass) begin
               cyc_addr = (step_reg == 3'd0) ? fmpc_pkg::UNLOCK_A1 : addr_reg;
               cyc_data = (step_reg == 3'd0) ? fmpc_pkg::CMD_PROG : data_reg;
            end else begin
               cyc_addr = (step_reg == 3'd1) ? fmpc_pkg::UNLOCK_A2 :
                          (step_reg == 3'd3) ? addr_reg : fmpc_pkg::UNLOCK_A1;
               cyc_data = (step_reg == 3'd0) ? fmpc_pkg::UNLOCK_D1 :
                          (step_reg == 3'd1) ? fmpc_pkg::UNLOCK_D2 :
                          (step_reg == 3'd2) ? fmpc_pkg::CMD_PROG : data_reg;
            end
         end
         fmpc_pkg::FMPC_OP_BYP_ON, fmpc_pkg::FMPC_OP_IDENT: begin
            cyc_addr = (step_reg == 3'd1) ? fmpc_pkg::UNLOCK_A2 : fmpc_pkg::UNLOCK_A1;
            cyc_data = (step_reg == 3'd0) ? fmpc_pkg::UNLOCK_D1 :
                       (step_reg == 3'd1) ? fmpc_pkg::UNLOCK_D2 :
                       (op_reg == fmpc_pkg::FMPC_OP_IDENT) ? fmpc_pkg::CMD_IDENT : fmpc_pkg::CMD_BYPASS;
         end
         fmpc_pkg::FMPC_OP_BYP_OFF: begin
            cyc_data = (step_reg == 3'd0) ? fmpc_pkg::CMD_BYP_EXIT0 : fmpc_pkg::CMD_BYP_EXIT1;
         end
         fmpc_pkg::FMPC_OP_RESET: begin
            cyc_data = fmpc_pkg::CMD_RESET;
         end
         fmpc_pkg::FMPC_OP_WRITE: begin
            // Raw protect writes; the caller orders them.
            cyc_read = 1'b0;
         end
         default: begin
            // Identification words are read like array data.
            cyc_read = in_ident;
         end
      endcase
   end

   assign go = (st_reg == FMPC_SEQ);
   // Operation sequencer.
   always_ff @(posedge clk_sys) begin
      op_done <= 1'b0;
      if (sys_rst) begin
         st_reg     <= FMPC_IDLE;
         op_reg     <= 3'b000;
         addr_reg   <= '0;
         data_reg   <= '0;
         step_reg   <= 3'd0;
         nsteps_reg <= 3'd0;
         tmr_reg    <= '0;
         op_ready   <= 1'b0;
         op_rdata   <= '0;
         clear_n    <= 1'b1;
      end else begin
         unique case (st_reg)
            FMPC_IDLE: begin
               op_ready <= 1'b1;
               if (op_valid) begin
                  op_ready <= 1'b0;
                  op_reg   <= op_code;
                  addr_reg <= op_addr;
                  data_reg <= op_data;
                  step_reg <= 3'd0;
                  unique case (op_code)
                     fmpc_pkg::FMPC_OP_PROG:    nsteps_reg <= (in_bypass ? 3'd1 : 3'd3);
                     fmpc_pkg::FMPC_OP_BYP_ON,
                     fmpc_pkg::FMPC_OP_IDENT:   nsteps_reg <= 3'd2;
                     fmpc_pkg::FMPC_OP_BYP_OFF: nsteps_reg <= 3'd1;
                     default:                   nsteps_reg <= 3'd0;
                  endcase
                  if (op_code == fmpc_pkg::FMPC_OP_CLEAR) begin
                     // Hold the clear pin low for its minimum pulse.
                     clear_n <= 1'b0;
                     tmr_reg <= fmpc_pkg::CNT_W'(fmpc_pkg::CLEAR_PULSE_CYC - 1);
                     st_reg  <= FMPC_CLEAR;
                  end else begin
                     st_reg <= FMPC_SEQ;
                  end
               end
            end
            FMPC_SEQ: begin
               st_reg <= FMPC_WAIT;
            end
            FMPC_WAIT: begin
               if (cyc_done) begin
                  op_rdata <= cyc_rdata;
                  if (step_reg == nsteps_reg) begin
                     st_reg <= FMPC_FIN;
                  end else begin
                     step_reg <= step_reg + 3'd1;
                     st_reg   <= FMPC_SEQ;
                  end
               end
            end
            FMPC_CLEAR: begin
               if (tmr_reg != '0) begin
                  tmr_reg <= tmr_reg - 1'b1;
               end else begin
                  clear_n <= 1'b1;
                  st_reg  <= FMPC_FIN;
               end
            end
            FMPC_FIN: begin
               op_done <= 1'b1;
               st_reg  <= FMPC_IDLE;
            end
            default: begin
               st_reg <= FMPC_IDLE;
            end
         endcase
      end
   end

   // Boost held only while the write-protect level is high and outside identification.
   assign boost_next = (wp_level && (op_reg == fmpc_pkg::FMPC_OP_PROG || wp_boost)
                        && !in_ident) ? wp_boost : 1'b0;
   // Tracks device mode as the device sees it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         in_ident  <= 1'b0;
         in_bypass <= 1'b0;
      end else if (st_reg == FMPC_CLEAR) begin
         // Clear returns the device to array read.
         in_ident  <= 1'b0;
         in_bypass <= 1'b0;
      end else if (st_reg == FMPC_FIN) begin
         unique case (op_reg)
            fmpc_pkg::FMPC_OP_IDENT:   in_ident  <= 1'b1;
            fmpc_pkg::FMPC_OP_RESET:   in_ident  <= 1'b0;
            fmpc_pkg::FMPC_OP_BYP_ON:  in_bypass <= 1'b1;
            fmpc_pkg::FMPC_OP_BYP_OFF: in_bypass <= 1'b0;
            default:                   in_bypass <= in_bypass;
         endcase
      end
   end

   // High-voltage flags for clear and write-protect pins.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         clear_hv <= 1'b0;
         wp_n     <= 1'b1;
         wp_boost <= 1'b0;
         a9_hv    <= 1'b0;
      end else begin
         // Separate flags; A9 never raised in-system.
         a9_hv    <= 1'b0;
         // Temporary unprotect while the flag stands, only idle.
         if (st_reg == FMPC_IDLE) begin
            clear_hv <= hv_clear_req;
         end
         wp_n     <= wp_level;
         // Boost raised only from idle with bypass off and not identifying.
         if (st_reg == FMPC_IDLE && op_valid && op_code == fmpc_pkg::FMPC_OP_BYP_ON && !in_ident
             && !in_bypass && wp_level && hv_clear_req == 1'b0) begin
            wp_boost <= 1'b1;
         end else if (!wp_level) begin
            wp_boost <= 1'b0;
         end else begin
            wp_boost <= boost_next;
         end
      end
   end

   clear_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(clear_n) |-> !clear_n [*8]) else $error("clear pulse too short");
   ident_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (in_ident && !(st_reg == FMPC_FIN && op_reg == fmpc_pkg::FMPC_OP_RESET) && st_reg != FMPC_CLEAR)
      |=> in_ident) else $error("identification left without reset");
   clear_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_reg == FMPC_CLEAR) |=> (!in_ident && !in_bypass)) else $error("mode kept over clear");
   a9_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !a9_hv) else $error("high voltage on address pin");
   boost_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(wp_boost) |-> !in_ident) else $error("boost raised outside array read");
   bypass_cnt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_reg == FMPC_IDLE && op_valid && op_code == fmpc_pkg::FMPC_OP_PROG && in_bypass)
      |=> nsteps_reg == 3'd1) else $error("bypass program not two writes");
   norm_cnt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_reg == FMPC_IDLE && op_valid && op_code == fmpc_pkg::FMPC_OP_PROG && !in_bypass)
      |=> nsteps_reg == 3'd3) else $error("program not four writes");
   wp_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !wp_level |=> !wp_boost) else $error("boost kept after write-protect low");
   prog_cov: cover property (@(posedge clk_sys) st_reg == FMPC_FIN && op_reg == fmpc_pkg::FMPC_OP_PROG);
   ident_cov: cover property (@(posedge clk_sys) $rose(in_ident));
   clear_cov: cover property (@(posedge clk_sys) $rose(clear_n));
endmodule
`default_nettype wire

// *** verilog/fmpc_cycle.sv ***
// Single bus cycle engine: one write or one read on the flash strobes.
`default_nettype none
module fmpc_cycle (
   // Clock and reset.
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   // Cycle request.
   input  wire logic                        go,
   input  wire logic                        is_read,
   input  wire logic [fmpc_pkg::ADDR_W-1:0] addr,
   input  wire logic [fmpc_pkg::DATA_W-1:0] wdata,
   output logic                             done,
   output logic [fmpc_pkg::DATA_W-1:0]      rdata,
   // Flash pins.
   output logic                             ce_n,
   output logic                             oe_n,
   output logic                             we_n,
   output logic [fmpc_pkg::ADDR_W-1:0]      a_out,
   output logic [fmpc_pkg::DATA_W-1:0]      dq_out,
   output logic                             dq_oe,
   input  wire logic [fmpc_pkg::DATA_W-1:0] dq_in
);
   timeunit 1ns / 100ps;
   logic [fmpc_pkg::CNT_W-1:0] cnt_reg;
   logic                       busy_reg;
   logic                       rd_reg;
   logic [fmpc_pkg::DATA_W-1:0] s1_reg;
   logic [fmpc_pkg::DATA_W-1:0] s2_reg;

   // Data pins pass two flops before capture.
   always_ff @(posedge clk_sys) begin
      s1_reg <= dq_in;
      s2_reg <= s1_reg;
   end

   // Strobe sequencing: write holds ce and we low with oe high; read holds ce and oe low.
   always_ff @(posedge clk_sys) begin
      done <= 1'b0;
      if (sys_rst) begin
         busy_reg <= 1'b0;
         rd_reg   <= 1'b0;
         cnt_reg  <= '0;
         ce_n     <= 1'b1;
         oe_n     <= 1'b1;
         we_n     <= 1'b1;
         dq_oe    <= 1'b0;
         a_out    <= '0;
         dq_out   <= '0;
         rdata    <= '0;
      end else if (!busy_reg && go) begin
         busy_reg <= 1'b1;
         rd_reg   <= is_read;
         a_out    <= addr;
         dq_out   <= wdata;
         ce_n     <= 1'b0;
         oe_n     <= !is_read;
         we_n     <= is_read;
         dq_oe    <= !is_read;
         cnt_reg  <= is_read ? fmpc_pkg::CNT_W'(fmpc_pkg::READ_CYC + 2)
                             : fmpc_pkg::CNT_W'(fmpc_pkg::STROBE_CYC);
      end else if (busy_reg) begin
         if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
         end else begin
            busy_reg <= 1'b0;
            ce_n     <= 1'b1;
            oe_n     <= 1'b1;
            we_n     <= 1'b1;
            dq_oe    <= 1'b0;
            done     <= 1'b1;
            if (rd_reg) begin
               rdata <= s2_reg;
            end
         end
      end
   end

   // Drive the data pins only with oe high.
   drive_excl_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      dq_oe |-> (oe_n && !we_n && !ce_n)) else $error("data driven outside a write");
   read_strobes_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!oe_n) |-> (we_n && !dq_oe)) else $error("read with write strobe low");
endmodule
`default_nettype wire

// *** verilog/fmpc_pkg.sv ***
// Package of constants for the flash mode and protection controller.
`default_nettype none
package fmpc_pkg;
   timeunit 1ns / 100ps;
   // Bus widths.
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // Bus timing in ns and derived cycle counts at the system clock.
   localparam int CLK_NS           = 25;
   localparam int STROBE_NS        = 50;
   localparam int STROBE_CYC       = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_NS          = 100;
   localparam int READ_CYC         = (READ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLEAR_PULSE_MIN_NS  = 500;
   localparam int CLEAR_PULSE_CYC  = (CLEAR_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BOOST_RAMP_MIN_NS   = 250;
   localparam int BOOST_RAMP_CYC   = (BOOST_RAMP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W            = 8;
   // Command words and unlock addresses.
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002aa;
   localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
   localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROG   = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_IDENT  = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
   localparam logic [DATA_W-1:0] CMD_RESET  = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_BYP_EXIT0 = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_BYP_EXIT1 = 16'h0000;
   // Identification offsets: address bits A1, A0 and A8.
   localparam logic [ADDR_W-1:0] ID_MAKER_A  = 22'h000100;
   localparam logic [ADDR_W-1:0] ID_CONFIG_A = 22'h000000;
   localparam logic [ADDR_W-1:0] ID_DEVICE_A = 22'h000001;
   localparam logic [ADDR_W-1:0] ID_GROUP_A  = 22'h000002;
   localparam int GROUP_LSB = 17;
   localparam logic [DATA_W-1:0] PROT_YES = 16'h0001;
   localparam logic [DATA_W-1:0] PROT_NO  = 16'h0000;
   // User operation codes.
   typedef enum logic [2:0] {
      FMPC_OP_READ    = 3'b000,
      FMPC_OP_PROG    = 3'b001,
      FMPC_OP_BYP_ON  = 3'b010,
      FMPC_OP_BYP_OFF = 3'b011,
      FMPC_OP_IDENT   = 3'b100,
      FMPC_OP_RESET   = 3'b101,
      FMPC_OP_WRITE   = 3'b110,
      FMPC_OP_CLEAR   = 3'b111
   } fmpc_op_e;
endpackage
`default_nettype wire
